/* dv/fbmd_flash_model.sv */
// behavioural flash device facing the host controller
`default_nettype none
module fbmd_flash_model
#(
    parameter logic [7:0] MAKER_CODE = 8'h07, // arbitrary, odd parity
    parameter logic [7:0] PART_CODE  = 8'h0b  // arbitrary, odd parity
)
(
    input  wire fbmd_pkg::fbmd_pins_s pins,
    input  wire logic [7:0]           dq_out,
    input  wire logic                 dq_oe_n,
    input  wire logic                 par_flip,
    output logic [7:0]                dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cmd_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [7:0] rd;
    logic       wr_q = 1'b0;
    wire rd_on = !pins.chip_sel_n && !pins.out_gate_n;
    // a write needs select and strobe low, gate high and program voltage on
    wire wr_on = !pins.chip_sel_n && !pins.write_en_n && pins.out_gate_n
                 && pins.program_voltage_high;
    wire idn = pins.identify_high_voltage
               || (pins.program_voltage_high && cmd_q == fbmd_pkg::CMD_IDENT);
    // array content is a fixed function of the address; par_flip spoils identifier parity
    assign rd = idn ? ((pins.addr[0] ? PART_CODE : MAKER_CODE) ^ {par_flip, 7'h00})
                    : pins.addr[7:0] ^ 8'h5a;
    // released bus shows the inverse of the last value, never a held copy
    assign dq_in = rd_on ? rd : (!dq_oe_n ? dq_out : ~last_q);
    always @*
        if (rd_on) last_q = rd;
    // byte latched when the write ends, whichever strobe rises first
    always @(wr_on or pins.program_voltage_high)
    begin
        if (pins.program_voltage_high !== 1'b1)
            cmd_q <= fbmd_pkg::CMD_READ;
        else if (wr_q === 1'b1 && wr_on === 1'b0)
            cmd_q <= dq_out;
        wr_q <= wr_on;
    end
endmodule
`default_nettype wire

/* dv/fbmd_host_assertions.sv */
// pin-level checks for the flash host controller
`default_nettype none
module fbmd_host_assertions
(
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire logic                 clk_en,
    input wire logic                 req_valid,
    input wire logic                 req_ready,
    input wire fbmd_pkg::fbmd_req_s  req,
    input wire logic                 vpp_high_req,
    input wire logic                 rsp_valid,
    input wire fbmd_pkg::fbmd_pins_s pins,
    input wire logic                 dq_oe_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire take = clk_en && req_valid && req_ready;
    wire wr = take && req.op == fbmd_pkg::OP_WRITE;
    a_write_vpp_high: assert property (!pins.write_en_n |-> pins.program_voltage_high)
        else $error("write strobe without program voltage");
    a_write_levels: assert property (!pins.write_en_n |-> !pins.chip_sel_n && pins.out_gate_n)
        else $error("write strobe with wrong select or gate");
    a_drive_gate_high: assert property (!dq_oe_n |-> pins.out_gate_n)
        else $error("host drives data while gate low");
    a_ident_addr_low: assert property (pins.identify_high_voltage |->
        pins.addr[16:1] == 16'h0000 && !pins.program_voltage_high)
        else $error("identifier mode with stray address or voltage");
    a_gate_needs_sel: assert property (!pins.out_gate_n |-> !pins.chip_sel_n)
        else $error("gate low without chip select");
    a_read_answer: assert property (take && req.op == fbmd_pkg::OP_READ |-> ##11 rsp_valid)
        else $error("read response late or missing");
    a_refused_write: assert property (wr && !vpp_high_req |=> pins.chip_sel_n [*8])
        else $error("write without voltage reached the pins");
    a_write_silent: assert property (wr |-> ##11 !rsp_valid)
        else $error("write produced a response");
    c_read: cover property (take && req.op == fbmd_pkg::OP_READ);
    c_write: cover property (!pins.write_en_n);
    c_ident: cover property (pins.identify_high_voltage);
endmodule
bind fbmd_host fbmd_host_assertions i_chk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .vpp_high_req(vpp_high_req),
    .rsp_valid(rsp_valid), .pins(pins), .dq_oe_n(dq_oe_n));
`default_nettype wire

/* dv/test_fbmd_host.sv */
// self-checking bench for the flash host controller
`default_nettype none
module test_fbmd_host;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MK = 8'h07; // arbitrary
    localparam logic [7:0] PT = 8'h0b; // arbitrary
    logic mclk = 0, rst_n = 0, clk_en = 1, req_valid = 0, vh = 0, req_ready, rsp_valid, perr;
    logic dq_oe_n, got, pf = 0;
    logic [7:0] rsp_data, dq_in, dq_out, d;
    fbmd_pkg::fbmd_req_s req = '0;
    fbmd_pkg::fbmd_pins_s pins;
    int bad_count = 0, tests_run = 0, cyc = 0;
    fbmd_host i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .vpp_high_req(vh), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_parity_err(perr), .pins(pins), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n));
    fbmd_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) i_flash (.pins(pins),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .par_flip(pf), .dq_in(dq_in));
    initial
        forever #5 mclk = ~mclk;
    task chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task stop_test();
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one whole transfer; waits past the answer slot so the next one is legal
    task xfer(input fbmd_pkg::fbmd_op_e op, input logic [16:0] a, input logic [7:0] w,
        input logic v);
        got = 0;
        d = 8'hxx;
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{op, a, w};
        vh <= v;
        @(posedge mclk);
        req_valid <= 1'b0;
        repeat (14)
        begin
            @(posedge mclk);
            #1;
            if (rsp_valid === 1'b1)
            begin
                got = 1;
                d = rsp_data;
            end
        end
    endtask
    task t_read();
        xfer(fbmd_pkg::OP_READ, 17'h00123, 8'h00, 1'b0);
        chk(d, 8'h79);
        chk(got, 1);
    endtask
    task t_ident();
        xfer(fbmd_pkg::OP_IDENT, 17'h00000, 8'h00, 1'b0);
        chk(d, MK);
        xfer(fbmd_pkg::OP_IDENT, 17'h00001, 8'h00, 1'b0);
        chk(d, PT);
        chk(^d, 1);
        chk(perr, 0);
    endtask
    task t_parity();
        @(posedge mclk);
        pf <= 1'b1;
        xfer(fbmd_pkg::OP_IDENT, 17'h00000, 8'h00, 1'b0);
        chk(d, MK ^ 8'h80);
        chk(perr, 1);
        pf <= 1'b0;
    endtask
    task t_cmd(input logic v, input logic [7:0] e);
        xfer(fbmd_pkg::OP_WRITE, 17'h00000, fbmd_pkg::CMD_IDENT, v);
        chk(got, 0);
        xfer(fbmd_pkg::OP_READ, 17'h00001, 8'h00, v);
        chk(d, e);
        xfer(fbmd_pkg::OP_WRITE, 17'h00000, fbmd_pkg::CMD_READ, v);
        xfer(fbmd_pkg::OP_READ, 17'h00001, 8'h00, v);
        chk(d, 8'h5b);
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_read();
        t_ident();
        t_parity();
        t_cmd(1'b0, 8'h5b);
        t_cmd(1'b1, PT);
        stop_test();
    end
endmodule
`default_nettype wire

/* rtl/fbmd_host.sv */
// host-side bus controller driving a byte-wide parallel flash
`default_nettype none
// Contract
// - read only with chip select and gate low
// - identifier byte by address bit zero
// - identifier mode: other addresses low, voltage low
// - write: select low, gate high, write low
module fbmd_host
(
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         clk_en,
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire fbmd_pkg::fbmd_req_s          req,
    input  wire logic                         vpp_high_req,
    output logic                              rsp_valid,
    output logic [fbmd_pkg::DATA_W-1:0]       rsp_data,
    output logic                              rsp_parity_err,
    output fbmd_pkg::fbmd_pins_s              pins,
    input  wire logic [fbmd_pkg::DATA_W-1:0]  dq_in,
    output logic [fbmd_pkg::DATA_W-1:0]       dq_out,
    output logic                              dq_oe_n
);
    fbmd_pkg::fbmd_state_e              state_q;
    fbmd_pkg::fbmd_req_s                cur_q;
    logic [3:0]                         cnt_q;
    logic [fbmd_pkg::DATA_W-1:0]        dq_meta_q;
    logic [fbmd_pkg::DATA_W-1:0]        dq_sync_q;
    logic                               vpp_q;
    logic                               rsp_valid_q;
    logic [fbmd_pkg::DATA_W-1:0]        rsp_data_q;
    logic                               rsp_perr_q;
    logic                               is_read;
    logic                               is_write;
    logic                               active;
    logic                               capture;
    logic                               wr_hold;

    // ***********************************
    // decode helpers
    // ***********************************
    // read and identifier cycles share one pin pattern
    function automatic logic op_reads(input fbmd_pkg::fbmd_op_e op);
        return (op == fbmd_pkg::OP_READ) || (op == fbmd_pkg::OP_IDENT);
    endfunction

    // identifier cycles raise the high-voltage address pin
    function automatic logic op_ident(input fbmd_pkg::fbmd_op_e op);
        return (op == fbmd_pkg::OP_IDENT);
    endfunction

    assign req_ready = (state_q == fbmd_pkg::ST_IDLE);
    assign is_read = op_reads(cur_q.op);
    // writes only while high program voltage is applied
    assign is_write = (cur_q.op == fbmd_pkg::OP_WRITE) && vpp_q;
    assign active = (state_q == fbmd_pkg::ST_SETUP) || (state_q == fbmd_pkg::ST_STROBE);
    // sample point: the synchroniser already holds data from inside the strobe
    assign capture = (state_q == fbmd_pkg::ST_DONE) && is_read;
    // select and data outlive the write strobe by one cycle, so the byte
    // latched on the rising strobe still has hold time behind it
    assign wr_hold = (state_q == fbmd_pkg::ST_DONE) && is_write;

    // ***********************************
    // pin synchroniser
    // ***********************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dq_meta_q <= 8'h00;
            dq_sync_q <= 8'h00;
        end
        else if (clk_en)
        begin
            // only the second stage feeds logic; the first may be metastable
            dq_meta_q <= dq_in;
            dq_sync_q <= dq_meta_q;
        end
    end

    // ***********************************
    // sequencer
    // ***********************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q <= fbmd_pkg::ST_IDLE;
            cnt_q <= fbmd_pkg::CNT_ZERO;
            cur_q <= '{op: fbmd_pkg::OP_IDLE, addr: '0, wdata: fbmd_pkg::CMD_READ};
            vpp_q <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (state_q)
                fbmd_pkg::ST_IDLE:
                begin
                    // voltage only changes between cycles, never mid-strobe
                    // request side is same-clock logic, so no synchroniser here
                    vpp_q <= vpp_high_req;
                    // a refused write still walks the full sequence: fixed timing
                    if (req_valid)
                    begin
                        cur_q <= req;
                        if (op_ident(req.op))
                        begin
                            // only bit zero may be nonzero
                            cur_q.addr <= '0;
                            cur_q.addr[fbmd_pkg::ADDR_ZERO] <= req.addr[fbmd_pkg::ADDR_ZERO];
                            vpp_q <= 1'b0;
                        end
                        cnt_q <= fbmd_pkg::SETUP_CNT;
                        state_q <= fbmd_pkg::ST_SETUP;
                    end
                end
                fbmd_pkg::ST_SETUP:
                begin
                    if (cnt_q == fbmd_pkg::CNT_ZERO)
                    begin
                        cnt_q <= fbmd_pkg::STROBE_CNT;
                        state_q <= fbmd_pkg::ST_STROBE;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                fbmd_pkg::ST_STROBE:
                begin
                    if (cnt_q == fbmd_pkg::CNT_ZERO)
                        state_q <= fbmd_pkg::ST_DONE;
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                fbmd_pkg::ST_DONE:
                    // deselect is safe: a running erase or program completes anyway
                    state_q <= fbmd_pkg::ST_IDLE;
                default:
                    state_q <= fbmd_pkg::ST_IDLE;
            endcase
        end
    end

    // ***********************************
    // pin drive
    // ***********************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pins <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_en_n: 1'b1,
                      program_voltage_high: 1'b0, identify_high_voltage: 1'b0, addr: '0};
        end
        else if (clk_en)
        begin
            pins.addr <= cur_q.addr;
            pins.program_voltage_high <= vpp_q;
            pins.identify_high_voltage <= active && op_ident(cur_q.op);
            // select dropped between cycles gives standby
            pins.chip_sel_n <= !((active && (is_read || is_write)) || wr_hold);
            // gate low only for reads, write enable held high then
            pins.out_gate_n <= !(active && is_read);
            pins.write_en_n <= !((state_q == fbmd_pkg::ST_STROBE) && is_write);
        end
    end

    // ***********************************
    // data drive
    // ***********************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dq_out <= 8'h00;
            dq_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            // host drives the bus only on a write, never with gate low
            dq_oe_n <= !((active && is_write) || wr_hold);
            dq_out <= cur_q.wdata;
        end
    end

    // ***********************************
    // read capture
    // ***********************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
            rsp_perr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            // response is registered, so it rises on the same edge that releases the pins
            rsp_valid_q <= capture;
            if (capture)
            begin
                rsp_data_q <= dq_sync_q;
                // a bad identifier byte is flagged, not corrected
                rsp_perr_q <= op_ident(cur_q.op)
                              && !fbmd_pkg::odd_parity(dq_sync_q);
            end
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_parity_err = rsp_perr_q;
endmodule
`default_nettype wire

/* rtl/fbmd_pkg.sv */
// package for the flash bus-mode host controller
`default_nettype none
package fbmd_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int ADDR_NINE = 9;
    localparam int ADDR_ZERO = 0;
    localparam int DATA_MSB_POS = 7;
    // read-mode command code, the register's default
    localparam logic [7:0] CMD_READ = 8'h00;
    // autoselect command code
    localparam logic [7:0] CMD_IDENT = 8'h90;
    // pin-phase lengths in ns (setup, strobe) and the mclk period in ns
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 70;
    localparam int CLK_NS = 10;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC - 1);
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC - 1);
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef enum logic [1:0]
    {
        OP_READ  = 2'b00,
        OP_IDENT = 2'b01,
        OP_WRITE = 2'b10,
        OP_IDLE  = 2'b11
    } fbmd_op_e;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b011,
        ST_DONE   = 3'b010
    } fbmd_state_e;

    typedef struct packed
    {
        fbmd_op_e           op;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
    } fbmd_req_s;

    typedef struct packed
    {
        logic               chip_sel_n;
        logic               out_gate_n;
        logic               write_en_n;
        logic               program_voltage_high;
        logic               identify_high_voltage;
        logic [ADDR_W-1:0]  addr;
    } fbmd_pins_s;

    // odd parity over a byte means the xor of all bits is one
    function automatic logic odd_parity(input logic [DATA_W-1:0] b);
        return ^b;
    endfunction
endpackage
`default_nettype wire
